/* hdl/cgr_config_regs.sv */
// How it works
// R01: index 2 bits 3..0 pick each diff output's edge rate; 1 is faster, reset 1.
// R02: index 2 bits 7..4 are reserved and steer nothing.
// R03: index 3 bits 7..6 pick reference edge rate, faster upward, reset 01.
// R04: index 3 bit 5 keeps reference running in power-down; reset 0.
// R05: index 3 bit 4 enables reference output; 0 forces it low; reset 1.
// R06: index 4 always reads all ones.
// R07: index 5 reads fixed revision code high and vendor code low.
// R08: index 6 reads two-bit part type and six-bit part code.
// R09: index 7 bits 4..0 set block-read length, reset 8; bit 7 reads 0.
// R10: block write: address, index, count, data bytes; every byte acknowledged.
// R11: block read: count byte first, then data; host ends with not-acknowledge.
// R12: writes to read-only or reserved bits are acknowledged yet change nothing.
`timescale 1ns/100ps
`default_nettype none

module cgr_config_regs #(
	parameter logic [6:0] SMB_ADDR = cgr_pkg::SMB_ADDR_DEF,
	parameter logic [3:0] REVISION_CODE = 4'h3, // arbitrary value
	parameter logic [3:0] VENDOR_CODE = 4'h5, // arbitrary value
	parameter logic [1:0] PART_TYPE = 2'h2, // arbitrary value
	parameter logic [5:0] PART_CODE = 6'h2a // arbitrary value
)(
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic SMB_SCL_I,
	input wire logic SMB_SDA_I,
	output logic SMB_SDA_O,
	output logic SMB_SDA_OE_O,
	input wire logic PWR_DOWN_I,
	output logic [3:0] DIFF_EDGE_RATE_SEL_O,
	output logic [1:0] REF_EDGE_RATE_O,
	output logic REF_RUN_IN_PD_O,
	output logic REF_OE_O,
	output logic REF_RUN_O
);
	import cgr_pkg::*;

	logic [2:0] sync_in;
	logic [2:0] sync_out;
	logic scl_s;
	logic sda_s;
	logic pd_s;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [7:0] rd_data;

	logic scl_q, scl_d;
	logic sda_q, sda_d;
	cgr_state_t state_q, state_d;
	cgr_phase_t phase_q, phase_d;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic [7:0] shift_q, shift_d;
	logic [7:0] tx_q, tx_d;
	logic [7:0] idx_q, idx_d;
	logic is_addr_q, is_addr_d;
	logic rw_q, rw_d;
	logic sda_oe_q, sda_oe_d;
	logic [3:0] diff_q, diff_d;
	logic [1:0] ref_edge_q, ref_edge_d;
	logic ref_run_pd_q, ref_run_pd_d;
	logic ref_oe_q, ref_oe_d;
	logic [4:0] read_len_q, read_len_d;
	logic ref_run_q, ref_run_d;

	assign sync_in = {PWR_DOWN_I, SMB_SDA_I, SMB_SCL_I};

	cgr_sync #(
		.WIDTH(3)
	) u_sync (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.d_i(sync_in),
		.q_o(sync_out)
	);

	assign scl_s = sync_out[0];
	assign sda_s = sync_out[1];
	assign pd_s = sync_out[2];
	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;
	assign start_c = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_c = scl_s & scl_q & ~sda_q & sda_s;

	// read view of the bank at the current index
	always_comb
	begin
		case (idx_q)
			IDX_DIFF_EDGE: rd_data = {4'h0, diff_q}; // [R02]
			IDX_REF_CTRL: rd_data = {ref_edge_q, ref_run_pd_q, ref_oe_q, REF_CTRL_RSVD_VAL, 2'h0};
			IDX_RSVD_ONES: rd_data = RSVD_ONES_VAL; // [R06]
			IDX_REV_VENDOR: rd_data = {REVISION_CODE, VENDOR_CODE}; // [R07]
			IDX_PART: rd_data = {PART_TYPE, PART_CODE}; // [R08]
			IDX_READ_LEN: rd_data = {3'h0, read_len_q}; // [R09]
			default: rd_data = 8'h00;
		endcase
	end

	always_comb
	begin
		scl_d = scl_s;
		sda_d = sda_s;
		state_d = state_q;
		phase_d = phase_q;
		bit_cnt_d = bit_cnt_q;
		shift_d = shift_q;
		tx_d = tx_q;
		idx_d = idx_q;
		is_addr_d = is_addr_q;
		rw_d = rw_q;
		sda_oe_d = sda_oe_q;
		diff_d = diff_q;
		ref_edge_d = ref_edge_q;
		ref_run_pd_d = ref_run_pd_q;
		ref_oe_d = ref_oe_q;
		read_len_d = read_len_q;
		ref_run_d = ref_oe_q & (~pd_s | ref_run_pd_q); // [R04] [R05]
		if (start_c)
		begin
			// start and repeated start both restart address phase, index kept
			state_d = ST_RX;
			bit_cnt_d = 4'h0;
			is_addr_d = 1'b1;
			sda_oe_d = 1'b0;
			phase_d = PH_INDEX;
		end
		else if (stop_c)
		begin
			state_d = ST_IDLE;
			sda_oe_d = 1'b0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					sda_oe_d = 1'b0;
				end
				ST_RX:
				begin
					if (scl_rise)
					begin
						shift_d = {shift_q[6:0], sda_s};
						bit_cnt_d = bit_cnt_q + 4'h1;
					end
					if (scl_fall && bit_cnt_q == BITS_PER_BYTE)
					begin
						bit_cnt_d = 4'h0;
						state_d = ST_ACK_OUT;
						sda_oe_d = 1'b1; // [R10]
						if (is_addr_q)
						begin
							is_addr_d = 1'b0;
							rw_d = shift_q[0];
							if (shift_q[7:1] != SMB_ADDR)
							begin
								state_d = ST_IDLE;
								sda_oe_d = 1'b0;
							end
							else if (shift_q[0])
							begin
								tx_d = {3'h0, read_len_q}; // [R11]
							end
						end
						else
						begin
							case (phase_q)
								PH_INDEX:
								begin
									idx_d = shift_q;
									phase_d = PH_COUNT;
								end
								PH_COUNT:
								begin
									phase_d = PH_DATA;
								end
								PH_DATA:
								begin
									idx_d = idx_q + 8'h01;
									case (idx_q)
										IDX_DIFF_EDGE: diff_d = shift_q[3:0]; // [R01]
										IDX_REF_CTRL:
										begin
											ref_edge_d = shift_q[REF_EDGE_MSB:REF_EDGE_LSB]; // [R03]
											ref_run_pd_d = shift_q[REF_RUN_PD_BIT]; // [R04]
											ref_oe_d = shift_q[REF_OE_BIT]; // [R05]
										end
										IDX_READ_LEN: read_len_d = shift_q[4:0]; // [R09]
										default: ; // [R12]
									endcase
								end
								default: phase_d = PH_INDEX;
							endcase
						end
					end
				end
				ST_ACK_OUT:
				begin
					if (scl_fall)
					begin
						if (rw_q)
						begin
							state_d = ST_TX;
							sda_oe_d = ~tx_q[7];
							bit_cnt_d = 4'h1;
						end
						else
						begin
							state_d = ST_RX;
							sda_oe_d = 1'b0;
						end
					end
				end
				ST_TX:
				begin
					if (scl_fall)
					begin
						if (bit_cnt_q == BITS_PER_BYTE)
						begin
							sda_oe_d = 1'b0;
							state_d = ST_ACK_IN;
						end
						else
						begin
							tx_d = {tx_q[6:0], 1'b0};
							sda_oe_d = ~tx_q[6];
							bit_cnt_d = bit_cnt_q + 4'h1;
						end
					end
				end
				ST_ACK_IN:
				begin
					if (scl_rise)
					begin
						if (sda_s)
						begin
							state_d = ST_IDLE; // [R11]
						end
						else
						begin
							tx_d = rd_data;
							idx_d = idx_q + 8'h01;
						end
					end
					if (scl_fall)
					begin
						state_d = ST_TX;
						sda_oe_d = ~tx_q[7];
						bit_cnt_d = 4'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I)
	begin
		if (SRST_I)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			state_q <= ST_IDLE;
			phase_q <= PH_INDEX;
			bit_cnt_q <= 4'h0;
			shift_q <= 8'h00;
			tx_q <= 8'h00;
			idx_q <= 8'h00;
			is_addr_q <= 1'b0;
			rw_q <= 1'b0;
			sda_oe_q <= 1'b0;
			diff_q <= DIFF_EDGE_RST; // [R01]
			ref_edge_q <= REF_EDGE_RST; // [R03]
			ref_run_pd_q <= REF_RUN_PD_RST;
			ref_oe_q <= REF_OE_RST;
			read_len_q <= READ_LEN_RST; // [R09]
			ref_run_q <= 1'b0;
		end
		else
		begin
			scl_q <= scl_d;
			sda_q <= sda_d;
			state_q <= state_d;
			phase_q <= phase_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			tx_q <= tx_d;
			idx_q <= idx_d;
			is_addr_q <= is_addr_d;
			rw_q <= rw_d;
			sda_oe_q <= sda_oe_d;
			diff_q <= diff_d;
			ref_edge_q <= ref_edge_d;
			ref_run_pd_q <= ref_run_pd_d;
			ref_oe_q <= ref_oe_d;
			read_len_q <= read_len_d;
			ref_run_q <= ref_run_d;
		end
	end

	assign SMB_SDA_O = 1'b0;
	assign SMB_SDA_OE_O = sda_oe_q;
	assign DIFF_EDGE_RATE_SEL_O = diff_q;
	assign REF_EDGE_RATE_O = ref_edge_q;
	assign REF_RUN_IN_PD_O = ref_run_pd_q;
	assign REF_OE_O = ref_oe_q;
	assign REF_RUN_O = ref_run_q;

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (SRST_I);

	sequence seq_byte_done;
		state_q == ST_RX && scl_fall && bit_cnt_q == BITS_PER_BYTE;
	endsequence

	sequence seq_addr_hit;
		seq_byte_done ##0 is_addr_q && shift_q[7:1] == SMB_ADDR;
	endsequence

	chk_diff_reset: assert property ($fell(SRST_I) |-> DIFF_EDGE_RATE_SEL_O == 4'hf) // [R01]
		else $error("diff edge selects not all ones after reset");
	chk_ref_edge_reset: assert property ($fell(SRST_I) |-> REF_EDGE_RATE_O == 2'h1 && !REF_RUN_IN_PD_O && REF_OE_O) // [R03]
		else $error("reference control not at reset code");
	chk_ref_gate: assert property (REF_RUN_O == $past(ref_oe_q && (!pd_s || ref_run_pd_q))) // [R04]
		else $error("reference run state disagrees with enable and power-down");
	chk_ref_oe_low: assert property (!ref_oe_q ##1 !ref_oe_q |-> !REF_RUN_O) // [R05]
		else $error("reference runs while disabled");
	chk_rsvd_ones: assert property (idx_q == IDX_RSVD_ONES |-> rd_data == 8'hff) // [R06]
		else $error("reserved index not all ones");
	chk_ro_fixed: assert property (idx_q == IDX_REV_VENDOR |-> rd_data == {REVISION_CODE, VENDOR_CODE}) // [R07]
		else $error("revision and vendor byte not fixed");
	chk_count_reset: assert property ($fell(SRST_I) |-> read_len_q == 5'h08) // [R09]
		else $error("read length not eight after reset");
	chk_addr_ack: assert property (seq_addr_hit |=> sda_oe_q && state_q == ST_ACK_OUT) // [R10]
		else $error("own address not acknowledged");
	chk_count_first: assert property (seq_addr_hit ##0 shift_q[0] |=> tx_q == {3'h0, read_len_q}) // [R11]
		else $error("block read does not open with the count");
	chk_nack_end: assert property (state_q == ST_ACK_IN && scl_rise && sda_s && !start_c && !stop_c
		|=> state_q == ST_IDLE && !sda_oe_q) // [R11]
		else $error("not-acknowledge did not end the read");
	chk_ro_write: assert property (seq_byte_done ##0 !is_addr_q && phase_q == PH_DATA && idx_q == IDX_PART
		|=> $stable(diff_q) && $stable(read_len_q) && $stable(ref_oe_q)) // [R12]
		else $error("write to read-only index changed state");

endmodule

`default_nettype wire

/* hdl/cgr_pkg.sv */
package cgr_pkg;

	// register indices
	localparam logic [7:0] IDX_DIFF_EDGE = 8'h02;
	localparam logic [7:0] IDX_REF_CTRL = 8'h03;
	localparam logic [7:0] IDX_RSVD_ONES = 8'h04;
	localparam logic [7:0] IDX_REV_VENDOR = 8'h05;
	localparam logic [7:0] IDX_PART = 8'h06;
	localparam logic [7:0] IDX_READ_LEN = 8'h07;

	// field positions in the reference control byte
	localparam int REF_EDGE_MSB = 7;
	localparam int REF_EDGE_LSB = 6;
	localparam int REF_RUN_PD_BIT = 5;
	localparam int REF_OE_BIT = 4;

	// reset and fixed read values
	localparam logic [3:0] DIFF_EDGE_RST = 4'hf;
	localparam logic [1:0] REF_EDGE_RST = 2'h1;
	localparam logic REF_RUN_PD_RST = 1'b0;
	localparam logic REF_OE_RST = 1'b1;
	localparam logic [1:0] REF_CTRL_RSVD_VAL = 2'h3;
	localparam logic [4:0] READ_LEN_RST = 5'h08;
	localparam logic [7:0] RSVD_ONES_VAL = 8'hff;

	// serial side
	localparam logic [6:0] SMB_ADDR_DEF = 7'h68;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX = 3'b001,
		ST_ACK_OUT = 3'b010,
		ST_TX = 3'b011,
		ST_ACK_IN = 3'b100
	} cgr_state_t;

	typedef enum logic [1:0] {
		PH_INDEX = 2'b00,
		PH_COUNT = 2'b01,
		PH_DATA = 2'b10
	} cgr_phase_t;

endpackage

/* hdl/cgr_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module cgr_sync #(
	parameter int WIDTH = 1
)(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	always_comb
	begin
		meta_d = d_i;
		sync_d = meta_q;
	end

	// idle bus lines are high, so reset to ones
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			meta_q <= '1;
			sync_q <= '1;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign q_o = sync_q;

endmodule

`default_nettype wire

/* verif/cgr_host.sv */
`timescale 1ns/100ps
`default_nettype none

module cgr_host (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic pull_o
);
	localparam int PH = 8;

	initial
	begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// also serves as repeated start
	task automatic start();
		pull_o = 1'b0;
		tick(PH);
		scl_o = 1'b1;
		tick(PH);
		pull_o = 1'b1;
		tick(PH);
		scl_o = 1'b0;
		tick(PH);
	endtask

	task automatic stop();
		pull_o = 1'b1;
		tick(PH);
		scl_o = 1'b1;
		tick(PH);
		pull_o = 1'b0;
		tick(PH);
	endtask

	// data set while scl low, sampled mid-high
	task automatic bit_io(input logic b, output logic s);
		pull_o = ~b;
		tick(PH);
		scl_o = 1'b1;
		tick(PH / 2);
		s = sda_i;
		tick(PH / 2);
		scl_o = 1'b0;
	endtask

	task automatic put_byte(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask

	// last byte answered by not-acknowledge
	task automatic get_byte(input logic last, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, s);
			v[i] = s;
		end
		bit_io(last, s);
	endtask
endmodule

`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none

module testbench;
	import cgr_pkg::*;
	localparam logic [3:0] REV = 4'h6; // arbitrary value
	localparam logic [3:0] VEN = 4'h9; // arbitrary value
	localparam logic [1:0] PTY = 2'h1; // arbitrary value
	localparam logic [5:0] PCD = 6'h15; // arbitrary value
	logic clk, srst, pd, scl, pull, sda_o, sda_oe, sda;
	logic [3:0] diff;
	logic [1:0] redge;
	logic rpd, roe, rrun;
	logic [7:0] wbuf[6];
	logic [7:0] rbuf[6];
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;

	assign sda = (sda_oe ? sda_o : 1'b1) & ~pull;

	cgr_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));

	cgr_config_regs #(.REVISION_CODE(REV), .VENDOR_CODE(VEN), .PART_TYPE(PTY),
		.PART_CODE(PCD)) dut (.CLK_I(clk), .SRST_I(srst), .SMB_SCL_I(scl),
		.SMB_SDA_I(sda), .SMB_SDA_O(sda_o), .SMB_SDA_OE_O(sda_oe),
		.PWR_DOWN_I(pd), .DIFF_EDGE_RATE_SEL_O(diff), .REF_EDGE_RATE_O(redge),
		.REF_RUN_IN_PD_O(rpd), .REF_OE_O(roe), .REF_RUN_O(rrun));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			bad_count++;
			close_out();
		end
	end

	task automatic close_out();
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic send(input logic [7:0] v);
		logic a;
		host.put_byte(v, a);
		check("ack", {7'h0, a}, 8'h01);
	endtask

	task automatic wr_block(input logic [7:0] idx, input int n);
		host.start();
		send({SMB_ADDR_DEF, 1'b0});
		send(idx);
		send(8'(n));
		for (int i = 0; i < n; i++)
			send(wbuf[i]);
		host.stop();
		settle(4);
	endtask

	task automatic rd_block(input logic [7:0] idx, input int n, input logic [7:0] cnt);
		logic [7:0] v;
		host.start();
		send({SMB_ADDR_DEF, 1'b0});
		send(idx);
		host.start();
		send({SMB_ADDR_DEF, 1'b1});
		host.get_byte(1'b0, v);
		check("count", v, cnt);
		for (int i = 0; i < n; i++)
		begin
			host.get_byte(i == n - 1, v);
			rbuf[i] = v;
		end
		host.stop();
	endtask

	task automatic t_reset();
		check("diff", {4'h0, diff}, {4'h0, DIFF_EDGE_RST});
		check("edge", {6'h0, redge}, {6'h0, REF_EDGE_RST});
		check("runpd", {7'h0, rpd}, {7'h0, REF_RUN_PD_RST});
		check("oe", {6'h0, roe, rrun}, 8'h03);
		rd_block(IDX_DIFF_EDGE, 6, {3'h0, READ_LEN_RST});
		check("b2", rbuf[0], {4'h0, DIFF_EDGE_RST});
		check("b3", rbuf[1], {REF_EDGE_RST, REF_RUN_PD_RST, REF_OE_RST, 4'hc});
		check("b4", rbuf[2], RSVD_ONES_VAL);
		check("b5", rbuf[3], {REV, VEN});
		check("b6", rbuf[4], {PTY, PCD});
		check("b7", rbuf[5], 8'h08);
	endtask

	task automatic t_wrong_addr();
		logic a;
		host.start();
		host.put_byte({SMB_ADDR_DEF ^ 7'h01, 1'b0}, a);
		check("nack", {7'h0, a}, 8'h00);
		host.stop();
	endtask

	task automatic t_write_all();
		wbuf = '{8'h5a, 8'h8f, 8'h00, 8'h00, 8'h00, 8'hf3};
		wr_block(IDX_DIFF_EDGE, 6);
		check("diffw", {4'h0, diff}, 8'h0a);
		check("refw", {redge, rpd, roe, 4'h0}, 8'h80);
		rd_block(IDX_DIFF_EDGE, 6, 8'h13);
		check("b2w", rbuf[0], 8'h0a);
		check("b3w", rbuf[1], 8'h8c);
		check("b4w", rbuf[2], 8'hff);
		check("b5w", rbuf[3], {REV, VEN});
		check("b6w", rbuf[4], {PTY, PCD});
		check("b7w", rbuf[5], 8'h13);
	endtask

	task automatic t_power();
		pd = 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			wbuf[0] = {2'(c), 6'h30};
			wr_block(IDX_REF_CTRL, 1);
			check("edgec", {6'h0, redge}, 8'(c));
			check("runpd", {6'h0, rpd, rrun}, 8'h03);
		end
		wbuf[0] = 8'h10;
		wr_block(IDX_REF_CTRL, 1);
		check("pdstop", {7'h0, rrun}, 8'h00);
		pd = 1'b0;
		settle(6);
		check("pdoff", {7'h0, rrun}, 8'h01);
		wbuf[0] = 8'h20;
		wr_block(IDX_REF_CTRL, 1);
		check("oelow", {7'h0, rrun}, 8'h00);
	endtask

	initial
	begin
		srst = 1'b1;
		pd = 1'b0;
		settle(12);
		srst = 1'b0;
		settle(6);
		t_reset();
		t_wrong_addr();
		t_write_all();
		t_power();
		close_out();
	end
endmodule

`default_nettype wire
